// ==== logic/ifd_decoder.sv ====
`timescale 1ns/1ps
// What this block does
// [RULE1] Every instruction is taken as one 12-bit word: opcode plus operands.
// [RULE2] Byte instructions select one of 32 file registers.
// [RULE3] Byte destination bit: 0 writes accumulator, 1 writes file register.
// [RULE4] Bit instructions choose one bit of the addressed 8-bit register.
// [RULE5] Literal instructions supply 8-bit constant, jump supplies 9-bit constant.
// [RULE6] Instructions take one cycle unless a test is true or PC changes.
// [RULE7] True test or PC change makes the instruction take two cycles.
// [RULE8] One instruction cycle is four oscillator periods.
// [RULE9] Don't-care bits never change decoded behaviour.
// [RULE10] Byte format: opcode 11..6, destination bit 5, register 4..0.
// [RULE11] Bit format: opcode 11..8, bit position 7..5, register 4..0.
// [RULE12] Literal format: opcode 11..8, constant 7..0.
// [RULE13] Jump format: opcode 11..9, constant 8..0.
// [RULE14] A two-cycle indication is output per decoded instruction.
module ifd_decoder
  import ifd_pkg::*;
#(
  parameter int WORD_W = INSN_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Fetch side
  input wire logic [WORD_W-1:0] insn_i,
  input wire logic insn_valid_i,
  // Datapath condition feedback
  input wire logic test_true_i,
  // Decoded fields
  output ifd_fields_s fields_o,
  output logic fields_valid_o,
  // Timing
  output logic [1:0] phase_o,
  output logic cycle_end_o,
  output logic two_cycle_o,
  output logic flush_o
);
  ////////////////////////////////////////////////////////////////////
  logic [1:0] phase;
  logic cycle_end;

  ifd_phase_counter u_phase (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .phase_o(phase),
    .cycle_end_o(cycle_end)
  );

  ////////////////////////////////////////////////////////////////////
  // Pure field extraction, shared between latch and checks
  function automatic ifd_fields_s decode(input logic [WORD_W-1:0] w);
    ifd_fields_s f;
    f = '0;
    f.file_sel = w[FILE_W-1:0]; // [RULE2] [RULE10] [RULE11]
    f.to_file = w[D_POS]; // [RULE3]
    f.bit_pos = w[B_LSB +: BIT_W]; // [RULE4] [RULE11]
    if (w[WORD_W-1 -: 2] == CLS_BYTE) begin
      f.cls = IFD_BYTE;
      // Among byte opcodes only the two count-and-test opcodes can skip
      f.may_skip = (w[WORD_W-1:OP6_LSB] == OP6_DEC_SKIP) || (w[WORD_W-1:OP6_LSB] == OP6_INC_SKIP); // [RULE6]
      // Return-style control word with no operands alters PC
      f.changes_pc = (w == INSN_RETURN_LIKE);
    end else if (w[WORD_W-1 -: 2] == CLS_BIT) begin
      f.cls = IFD_BITOP;
      f.may_skip = (w[WORD_W-1:OP4_LSB] == OP4_SKIP_CLR) || (w[WORD_W-1:OP4_LSB] == OP4_SKIP_SET); // [RULE6]
    end else if (w[WORD_W-1:OP3_LSB] == OP3_JUMP) begin
      f.cls = IFD_JUMP;
      f.literal = w[JLIT_W-1:0]; // [RULE5] [RULE13]
      f.changes_pc = 1'b1; // [RULE7]
    end else begin
      f.cls = IFD_LIT;
      f.literal = {1'b0, w[LIT_W-1:0]}; // [RULE5] [RULE12]
      f.changes_pc = (w[WORD_W-1:OP4_LSB] == OP4_RET_LIT) || (w[WORD_W-1:OP3_LSB] == OP3_CALL); // [RULE7]
    end
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Fields are latched at the start of an instruction cycle and stand for all four periods
  ifd_fields_s fields;
  ifd_fields_s next_fields;
  logic fields_valid;
  logic next_fields_valid;
  logic two_cycle;
  logic next_two_cycle;
  logic flush;
  logic next_flush;

  always_comb begin
    next_fields = fields;
    next_fields_valid = fields_valid;
    next_two_cycle = two_cycle;
    next_flush = flush;
    if (cycle_end) begin
      // Test result comes from the datapath during the executing cycle
      next_two_cycle = fields_valid && (fields.changes_pc || (fields.may_skip && test_true_i)); // [RULE6] [RULE7]
      next_flush = next_two_cycle; // [RULE14]
      // The word fetched behind a taken branch or skip is dropped, which makes the extra cycle
      if (insn_valid_i && !next_two_cycle) begin
        next_fields = decode(insn_i); // [RULE1] [RULE9]
        next_fields_valid = 1'b1;
      end else begin
        next_fields_valid = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fields <= '0;
      fields_valid <= 1'b0;
      two_cycle <= 1'b0;
      flush <= 1'b0;
    end else begin
      fields <= next_fields;
      fields_valid <= next_fields_valid;
      two_cycle <= next_two_cycle;
      flush <= next_flush;
    end
  end

  assign fields_o = fields;
  assign fields_valid_o = fields_valid;
  assign phase_o = phase;
  assign cycle_end_o = cycle_end;
  assign two_cycle_o = two_cycle;
  assign flush_o = flush;

  ////////////////////////////////////////////////////////////////////
  // Check-only view of the incoming word and of the decision to take it
  ifd_fields_s chk;
  logic take;
  assign chk = decode(insn_i);
  assign take = cycle_end && insn_valid_i && !next_two_cycle;

  // Field extraction from a taken word
  a_file_field: assert property (@(posedge clk_i) disable iff (!nrst_i)
    take |=> (fields.file_sel == $past(insn_i[FILE_W-1:0]))) // [RULE2]
    else $error("register number not taken from bits 4..0");
  a_dest_bit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    take |=> (fields.to_file == $past(insn_i[D_POS]))) // [RULE3]
    else $error("destination bit not taken from bit 5");
  a_bit_pos: assert property (@(posedge clk_i) disable iff (!nrst_i)
    take |=> (fields.bit_pos == $past(insn_i[B_LSB +: BIT_W]))) // [RULE4]
    else $error("bit position not taken from bits 7..5");
  a_jump_lit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (take && chk.cls == IFD_JUMP)
      |=> (fields.literal == $past(insn_i[JLIT_W-1:0]) && fields.changes_pc)) // [RULE13]
    else $error("jump constant or pc change wrong");
  a_lit_eight: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (take && chk.cls == IFD_LIT)
      |=> (fields.literal == {1'b0, $past(insn_i[LIT_W-1:0])})) // [RULE12]
    else $error("literal constant not taken from bits 7..0");
  a_lit_unused: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (take && (chk.cls == IFD_BYTE || chk.cls == IFD_BITOP)) |=> (fields.literal == '0)) // [RULE9]
    else $error("unused constant field follows instruction bits");

  // Class, pc-change and skip decoding from the raw opcode bits
  a_byte_class: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (take && insn_i[WORD_W-1 -: 2] == CLS_BYTE) |=> (fields.cls == IFD_BYTE)) // [RULE10]
    else $error("byte format word not decoded as byte class");
  a_bit_class: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (take && insn_i[WORD_W-1 -: 2] == CLS_BIT) |=> (fields.cls == IFD_BITOP)) // [RULE11]
    else $error("bit format word not decoded as bit class");
  a_jump_class: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (take && insn_i[WORD_W-1:OP3_LSB] == OP3_JUMP) |=> (fields.cls == IFD_JUMP)) // [RULE13]
    else $error("jump word not decoded as jump class");
  a_call_pc: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (take && insn_i[WORD_W-1:OP3_LSB] == OP3_CALL) |=> fields.changes_pc) // [RULE7]
    else $error("call word not marked as pc change");
  a_skip_marked: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (take && insn_i[WORD_W-1:OP4_LSB] == OP4_SKIP_CLR) |=> fields.may_skip) // [RULE6]
    else $error("bit test word not marked as skipping");
  a_plain_byte: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (take && insn_i[WORD_W-1 -: 2] == CLS_BYTE && insn_i != INSN_RETURN_LIKE) |=> !fields.changes_pc) // [RULE6]
    else $error("plain byte word marked as pc change");

  // Taking and dropping words
  a_word_taken: assert property (@(posedge clk_i) disable iff (!nrst_i)
    take |=> fields_valid) // [RULE1]
    else $error("offered word not taken");
  a_idle_drop: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cycle_end && !insn_valid_i) |=> !fields_valid) // [RULE1]
    else $error("cycle without a word marked valid");

  // Cycle timing
  a_fields_stand: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cycle_end |=> $stable(fields) && $stable(two_cycle)) // [RULE1]
    else $error("decoded fields changed mid instruction cycle");
  a_pc_two_cyc: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cycle_end && fields_valid && fields.changes_pc) |=> two_cycle ##1 two_cycle[*3]) // [RULE7]
    else $error("pc change did not give a second cycle");
  a_one_cycle: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cycle_end && fields_valid && !fields.changes_pc && !(fields.may_skip && test_true_i)) |=> !two_cycle) // [RULE6]
    else $error("plain instruction took two cycles");
  a_flush_drop: assert property (@(posedge clk_i) disable iff (!nrst_i)
    two_cycle |-> !fields_valid) // [RULE14]
    else $error("fetched word not discarded in second cycle");
  a_skip_two_cyc: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cycle_end && fields_valid && fields.may_skip && test_true_i) |=> two_cycle) // [RULE7]
    else $error("true skip test did not give a second cycle");
  a_extra_once: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cycle_end && two_cycle) |=> !two_cycle) // [RULE7]
    else $error("extra cycle lasted more than one instruction cycle");
  a_valid_stand: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cycle_end |=> $stable(fields_valid) && $stable(flush)) // [RULE6]
    else $error("valid or flush changed mid instruction cycle");
  a_cycle_len: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cycle_end |=> !cycle_end[*3] ##1 cycle_end) // [RULE8]
    else $error("instruction cycle not four periods");

  c_skip_taken: cover property (@(posedge clk_i) disable iff (!nrst_i)
    cycle_end && fields_valid && fields.may_skip && test_true_i);
  c_jump: cover property (@(posedge clk_i) disable iff (!nrst_i)
    cycle_end && fields_valid && fields.cls == IFD_JUMP);
  c_bit_op: cover property (@(posedge clk_i) disable iff (!nrst_i)
    cycle_end && fields_valid && fields.cls == IFD_BITOP);
  c_byte_to_file: cover property (@(posedge clk_i) disable iff (!nrst_i)
    fields_valid && fields.cls == IFD_BYTE && fields.to_file);
  c_word_refused: cover property (@(posedge clk_i) disable iff (!nrst_i)
    cycle_end && next_two_cycle && insn_valid_i);
endmodule

// ==== logic/ifd_phase_counter.sv ====
`timescale 1ns/1ps
module ifd_phase_counter
  import ifd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Phase
  output logic [1:0] phase_o,
  output logic cycle_end_o
);
  logic [1:0] phase;
  logic [1:0] next_phase;

  always_comb begin
    next_phase = phase + 2'h1; // [RULE8]
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase <= PHASE_FIRST;
    end else begin
      phase <= next_phase;
    end
  end

  assign phase_o = phase;
  assign cycle_end_o = (phase == PHASE_LAST);

  a_phase_wrap: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (phase == PHASE_LAST) |=> (phase == PHASE_FIRST)) // [RULE8]
    else $error("phase did not wrap after four periods");
endmodule

// ==== logic/ifd_pkg.sv ====
package ifd_pkg;
  localparam int INSN_W = 12;
  localparam int FILE_W = 5;
  localparam int BIT_W = 3;
  localparam int LIT_W = 8;
  localparam int JLIT_W = 9;
  localparam int PHASES = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_FIRST = 2'h0;

  // Field positions
  localparam int D_POS = 5;
  localparam int B_LSB = 5;
  localparam int OP6_LSB = 6;
  localparam int OP4_LSB = 8;
  localparam int OP3_LSB = 9;

  // Opcode bits used for class, pc-change and skip decoding
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_LIT = 2'h3;
  localparam logic [2:0] OP3_JUMP = 3'h5;
  localparam logic [2:0] OP3_CALL = 3'h4;
  localparam logic [3:0] OP4_RET_LIT = 4'h8;
  localparam logic [3:0] OP4_SKIP_CLR = 4'h6;
  localparam logic [3:0] OP4_SKIP_SET = 4'h7;
  localparam logic [5:0] OP6_DEC_SKIP = 6'h0B;
  localparam logic [5:0] OP6_INC_SKIP = 6'h0F;
  localparam logic [11:0] INSN_RETURN_LIKE = 12'h002;

  typedef enum logic [1:0] {
    IFD_BYTE = 2'b00,
    IFD_BITOP = 2'b01,
    IFD_LIT = 2'b10,
    IFD_JUMP = 2'b11
  } ifd_class_e;

  typedef struct packed {
    ifd_class_e cls;
    logic [FILE_W-1:0] file_sel;
    logic to_file;
    logic [BIT_W-1:0] bit_pos;
    logic [JLIT_W-1:0] literal;
    logic changes_pc;
    logic may_skip;
  } ifd_fields_s;
endpackage

// ==== testbench/ifd_fetch_model.sv ====
`timescale 1ns/1ps
module ifd_fetch_model
  import ifd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Bench and decoder side
  input wire logic [INSN_W-1:0] word_i,
  input wire logic valid_i,
  input wire logic cycle_end_i,
  // Fetch bus
  output logic [INSN_W-1:0] insn_o,
  output logic insn_valid_o
);
  // An idle bus flips every clock between cycle ends so a stale word never passes for a fresh one
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      insn_o <= 12'hA5A;
      insn_valid_o <= 1'b0;
    end else if (cycle_end_i) begin
      insn_o <= word_i;
      insn_valid_o <= valid_i;
    end else if (!insn_valid_o) begin
      insn_o <= ~insn_o;
    end
  end
endmodule

// ==== testbench/tb_instruction_field_decoder.sv ====
`timescale 1ns/1ps
module tb_instruction_field_decoder;
  import ifd_pkg::*;
  typedef struct packed {logic v; logic two; ifd_fields_s f;} ifd_note_s;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [INSN_W-1:0] word = 12'h000;
  logic [INSN_W-1:0] insn;
  logic [INSN_W-1:0] pw = 12'h000;
  logic wvalid = 1'b0;
  logic pv = 1'b0;
  logic test_true = 1'b0;
  logic insn_valid, fields_valid, cycle_end, two_cycle, flush;
  logic [1:0] phase;
  ifd_fields_s fields;
  ifd_fields_s ex;
  logic ex_v = 1'b0;
  int err_total = 0;
  int tests_run = 0;
  ifd_note_s notes[$];
  ////////////////////////////////////////
  initial forever #4 clk_i = ~clk_i;
  ifd_fetch_model u_fetch (.clk_i(clk_i), .nrst_i(nrst_i), .word_i(word), .valid_i(wvalid),
    .cycle_end_i(cycle_end), .insn_o(insn), .insn_valid_o(insn_valid));
  ifd_decoder u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .insn_i(insn), .insn_valid_i(insn_valid),
    .test_true_i(test_true), .fields_o(fields), .fields_valid_o(fields_valid), .phase_o(phase),
    .cycle_end_o(cycle_end), .two_cycle_o(two_cycle), .flush_o(flush));
  ////////////////////////////////////////
  function automatic ifd_fields_s decode(logic [INSN_W-1:0] w);
    ifd_fields_s f;
    f = '0;
    f.file_sel = w[4:0];
    f.to_file = w[5];
    f.bit_pos = w[7:5];
    f.literal = {1'b0, w[7:0]};
    f.cls = (w[11:10] == 2'h0) ? IFD_BYTE : (w[11:10] == 2'h1) ? IFD_BITOP : IFD_LIT;
    if (w[11:9] == 3'h5) begin
      f.cls = IFD_JUMP;
      f.literal = w[8:0];
    end
    f.changes_pc = (w[11:9] == 3'h5) || (w[11:9] == 3'h4) || (w == 12'h002);
    f.may_skip = (w[11:6] == 6'h0B) || (w[11:6] == 6'h0F) || (w[11:9] == 3'h3);
    return f;
  endfunction
  task automatic cmp(string name, logic [INSN_W-1:0] exp, logic [INSN_W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Timing and handshake results
  task automatic cmp_time(string name, logic [1:0] exp, logic [1:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One call per instruction cycle; calls must follow each other without gaps
  task automatic step(logic [INSN_W-1:0] w, logic v, logic tt);
    ifd_note_s n;
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      #1;
      k++;
    end while (phase !== 2'h2 && k < 8);
    @(posedge clk_i);
    test_true <= tt;
    word <= w;
    wvalid <= v;
    @(posedge clk_i);
    n.two = ex_v && (ex.changes_pc || (ex.may_skip && tt));
    n.v = !n.two && pv;
    n.f = decode(pw);
    ex = n.f;
    ex_v = n.v;
    notes.push_back(n);
    pw = w;
    pv = v;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    ifd_note_s n;
    logic [1:0] ph;
    ph = 2'h0;
    @(posedge nrst_i);
    forever begin
      @(posedge clk_i);
      #1;
      ph = ph + 2'h1;
      cmp_time("phase", ph, phase);
      cmp_time("cycle_end", ph == 2'h3, cycle_end);
      if (ph == 2'h0 && notes.size() > 0) begin
        n = notes.pop_front();
        cmp_time("valid", n.v, fields_valid);
        cmp_time("two_cycle", n.two, two_cycle);
        cmp_time("flush", n.two, flush);
        if (n.v) cmp("class", n.f.cls, fields.cls);
        if (n.v) cmp("changes_pc", n.f.changes_pc, fields.changes_pc);
        if (n.v) cmp("may_skip", n.f.may_skip, fields.may_skip);
        if (n.v && n.f.cls == IFD_BYTE) cmp("to_file", n.f.to_file, fields.to_file);
        if (n.v && n.f.cls == IFD_BYTE) cmp("file_sel", n.f.file_sel, fields.file_sel);
        if (n.v && n.f.cls == IFD_BITOP) cmp("bit_file", n.f.file_sel, fields.file_sel);
        if (n.v && n.f.cls == IFD_BITOP) cmp("bit_pos", n.f.bit_pos, fields.bit_pos);
        if (n.v && n.f.cls == IFD_LIT) cmp("literal", n.f.literal, fields.literal);
        if (n.v && n.f.cls == IFD_JUMP) cmp("jump_lit", n.f.literal, fields.literal);
      end
    end
  end
  initial begin
    #40000;
    err_total++;
    end_of_test();
  end
  initial begin
    int i;
    logic [INSN_W-1:0] dir [8] = '{12'hA35, 12'hBC4, 12'h8F0, 12'h002, 12'h2C7, 12'h6A3, 12'h03F, 12'hCFF};
    void'($urandom(18649));
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    // Back-to-back jumps land a word in the flushed slot on purpose
    for (i = 0; i < 16; i++) step(dir[i % 8], 1'b1, i[3]);
    for (i = 0; i < 300; i++) step(12'($urandom), 1'($urandom), 1'($urandom));
    step(12'h000, 1'b0, 1'b0);
    @(posedge clk_i);
    #2;
    end_of_test();
  end
endmodule
